// ===== rtl/dtc_params.svh
// constants for the dual timer/counter block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_TL0 8'h8A
`define DTC_IDX_TL1 8'h8B
`define DTC_IDX_TH0 8'h8C
`define DTC_IDX_TH1 8'h8D
`define DTC_ADDR_CTRL {2'h0, `DTC_IDX_CTRL, 2'h0}
`define DTC_ADDR_MODE {2'h0, `DTC_IDX_MODE, 2'h0}
`define DTC_ADDR_TL0 {2'h0, `DTC_IDX_TL0, 2'h0}
`define DTC_ADDR_TL1 {2'h0, `DTC_IDX_TL1, 2'h0}
`define DTC_ADDR_TH0 {2'h0, `DTC_IDX_TH0, 2'h0}
`define DTC_ADDR_TH1 {2'h0, `DTC_IDX_TH1, 2'h0}
`define DTC_ADDR_ACK 12'h090
`define DTC_ADDR_IRQ_STAT 12'h094
`define DTC_ADDR_IRQ_MASK 12'h098
`define DTC_CTRL_RST 8'h00
`define DTC_MODE_RST 8'h00
`define DTC_BIT_TF1 7
`define DTC_BIT_TR1 6
`define DTC_BIT_TF0 5
`define DTC_BIT_TR0 4
`define DTC_BIT_IE1 3
`define DTC_BIT_IT1 2
`define DTC_BIT_IE0 1
`define DTC_BIT_IT0 0
`define DTC_BIT_TIMER_ONE_PIN_GATING 7
`define DTC_BIT_CS1 6
`define DTC_BIT_TIMER_ZERO_PIN_GATING 3
`define DTC_BIT_CS0 2
`define DTC_PRESCALE_MAX 5'h1F
`define DTC_TICK_DIV 2
`endif

// ===== rtl/dtc_pkg.sv
// types for the dual timer/counter block
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_PRESCALE = 2'b00,
		DTC_MODE_WIDE = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_e;
	typedef struct packed {
		logic int_zero;
		logic int_one;
		logic cnt_zero;
		logic cnt_one;
	} dtc_pins_s;
	typedef struct packed {
		logic tf1;
		logic tf0;
		logic ie1;
		logic ie0;
	} dtc_ack_s;
endpackage

// ===== rtl/dtc_timer.sv
// two timer/counters with external interrupt detection, apb slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "dtc_params.svh"
// Operation
// - overflow of timer one sets its flag
// - timer one counts only when run set
// - overflow of timer zero sets its flag
// - timer zero counts only when run zero set; split-mode th0 counts on run one
// - int one falling edge sets edge flag
// - int one trigger: level or edge
// - int zero falling edge sets edge flag
// - int zero trigger: level or edge
// - gate one needs int one pin high
// - gate zero needs int zero pin high
// - timer one ticks every two clocks
// - timer one counts pin falling edges
// - timer zero source: clocks or pin edges
// - timer one modes prescale and sixteen bit
// - timer one reload mode, or stopped
// - timer zero prescale mode
// - timer zero sixteen bit and reload
// - timer zero split into two counters
module dtc_timer import dtc_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dtc_pins_s pins,
	input wire dtc_ack_s vector_ack,
	output logic timer_one_overflow_flag,
	output logic timer_zero_overflow_flag,
	output logic ext_int_one_request,
	output logic ext_int_zero_request,
	output logic irq
);
	// ***************
	// pin sampling
	// ***************
	dtc_pins_s sync1_q, sync2_q, prev_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 4'hF;
			sync2_q <= 4'hF;
			prev_q <= 4'hF;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	wire dtc_pins_s fall = prev_q & ~sync2_q;

	// ***************
	// registers
	// ***************
	logic [7:0] ctrl_q, mode_q, tl0_q, tl1_q, th0_q, th1_q;
	logic [3:0] stat_q, mask_q;
	logic tick_q;
	logic wr;
	assign wr = psel && penable && pwrite;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = (a == b);
	endfunction

	// prescaler tick, every two clocks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= ~tick_q;
		end
	end

	// ***************
	// count enables
	// ***************
	dtc_mode_e m0, m1;
	assign m0 = dtc_mode_e'(mode_q[1:0]);
	assign m1 = dtc_mode_e'(mode_q[5:4]);
	logic run0, run1, inc0, inc1, inc_th0;
	always_comb begin
		run0 = ctrl_q[`DTC_BIT_TR0]
			&& (!mode_q[`DTC_BIT_TIMER_ZERO_PIN_GATING] || sync2_q.int_zero);
		run1 = ctrl_q[`DTC_BIT_TR1]
			&& (!mode_q[`DTC_BIT_TIMER_ONE_PIN_GATING] || sync2_q.int_one);
		inc0 = run0 && (mode_q[`DTC_BIT_CS0] ? fall.cnt_zero : tick_q);
		inc1 = run1 && (mode_q[`DTC_BIT_CS1] ? fall.cnt_one : tick_q);
		inc_th0 = ctrl_q[`DTC_BIT_TR1] && tick_q;
	end

	// ***************
	// timer zero
	// ***************
	logic ovf0, ovf_th0;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tl0_q <= 8'h00;
			th0_q <= 8'h00;
			ovf0 <= 1'b0;
			ovf_th0 <= 1'b0;
		end else begin
			ovf0 <= 1'b0;
			ovf_th0 <= 1'b0;
			if (wr && hit(paddr, `DTC_ADDR_TL0)) begin
				tl0_q <= pwdata[7:0];
			end else if (inc0) begin
				case (m0)
					DTC_MODE_PRESCALE: begin
						tl0_q <= {3'h0, tl0_q[4:0] + 5'h01};
					end
					DTC_MODE_WIDE: begin
						tl0_q <= tl0_q + 8'h01;
					end
					DTC_MODE_RELOAD: begin
						tl0_q <= (tl0_q == 8'hFF) ? th0_q : tl0_q + 8'h01;
						ovf0 <= (tl0_q == 8'hFF);
					end
					default: begin
						tl0_q <= tl0_q + 8'h01;
						ovf0 <= (tl0_q == 8'hFF);
					end
				endcase
			end
			if (wr && hit(paddr, `DTC_ADDR_TH0)) begin
				th0_q <= pwdata[7:0];
			end else if (m0 == DTC_MODE_SPLIT) begin
				if (inc_th0) begin
					th0_q <= th0_q + 8'h01;
					ovf_th0 <= (th0_q == 8'hFF);
				end
			end else if (inc0 && m0 == DTC_MODE_PRESCALE
				&& tl0_q[4:0] == `DTC_PRESCALE_MAX) begin
				th0_q <= th0_q + 8'h01;
				ovf0 <= (th0_q == 8'hFF);
			end else if (inc0 && m0 == DTC_MODE_WIDE && tl0_q == 8'hFF) begin
				th0_q <= th0_q + 8'h01;
				ovf0 <= (th0_q == 8'hFF);
			end
		end
	end

	// ***************
	// timer one
	// ***************
	logic ovf1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tl1_q <= 8'h00;
			th1_q <= 8'h00;
			ovf1 <= 1'b0;
		end else begin
			ovf1 <= 1'b0;
			if (wr && hit(paddr, `DTC_ADDR_TL1)) begin
				tl1_q <= pwdata[7:0];
			end else if (inc1) begin
				case (m1)
					DTC_MODE_PRESCALE: begin
						tl1_q <= {3'h0, tl1_q[4:0] + 5'h01};
					end
					DTC_MODE_WIDE: begin
						tl1_q <= tl1_q + 8'h01;
					end
					DTC_MODE_RELOAD: begin
						tl1_q <= (tl1_q == 8'hFF) ? th1_q : tl1_q + 8'h01;
						ovf1 <= (tl1_q == 8'hFF);
					end
					default: begin
						tl1_q <= tl1_q;
					end
				endcase
			end
			if (wr && hit(paddr, `DTC_ADDR_TH1)) begin
				th1_q <= pwdata[7:0];
			end else if (inc1 && ((m1 == DTC_MODE_PRESCALE
				&& tl1_q[4:0] == `DTC_PRESCALE_MAX)
				|| (m1 == DTC_MODE_WIDE && tl1_q == 8'hFF))) begin
				th1_q <= th1_q + 8'h01;
				ovf1 <= (th1_q == 8'hFF);
			end
		end
	end

	// ***************
	// control register and flags
	// ***************
	logic set_tf1, set_tf0, set_ie1, set_ie0;
	always_comb begin
		set_tf1 = ovf1 || ovf_th0;
		set_tf0 = ovf0;
		set_ie1 = ctrl_q[`DTC_BIT_IT1] && fall.int_one;
		set_ie0 = ctrl_q[`DTC_BIT_IT0] && fall.int_zero;
	end
	// flag bits: set wins over clear by write or vector
	function automatic logic flag_nx(input logic cur, input logic set, input logic wen,
		input logic wv, input logic ack);
		flag_nx = set || (wen ? wv : (cur && !ack));
	endfunction
	logic wc;
	assign wc = wr && hit(paddr, `DTC_ADDR_CTRL);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `DTC_CTRL_RST;
		end else begin
			ctrl_q[`DTC_BIT_TF1] <= flag_nx(ctrl_q[`DTC_BIT_TF1], set_tf1, wc,
				pwdata[`DTC_BIT_TF1], vector_ack.tf1);
			ctrl_q[`DTC_BIT_TF0] <= flag_nx(ctrl_q[`DTC_BIT_TF0], set_tf0, wc,
				pwdata[`DTC_BIT_TF0], vector_ack.tf0);
			ctrl_q[`DTC_BIT_IE1] <= flag_nx(ctrl_q[`DTC_BIT_IE1], set_ie1, wc,
				pwdata[`DTC_BIT_IE1], vector_ack.ie1);
			ctrl_q[`DTC_BIT_IE0] <= flag_nx(ctrl_q[`DTC_BIT_IE0], set_ie0, wc,
				pwdata[`DTC_BIT_IE0], vector_ack.ie0);
			if (wc) begin
				ctrl_q[`DTC_BIT_TR1] <= pwdata[`DTC_BIT_TR1];
				ctrl_q[`DTC_BIT_TR0] <= pwdata[`DTC_BIT_TR0];
				ctrl_q[`DTC_BIT_IT1] <= pwdata[`DTC_BIT_IT1];
				ctrl_q[`DTC_BIT_IT0] <= pwdata[`DTC_BIT_IT0];
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= `DTC_MODE_RST;
		end else if (wr && hit(paddr, `DTC_ADDR_MODE)) begin
			mode_q <= pwdata[7:0];
		end
	end

	// ***************
	// interrupt status and mask
	// ***************
	logic [3:0] ev;
	assign ev = {set_tf1, set_tf0, set_ie1, set_ie0};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_q <= 4'h0;
			mask_q <= 4'h0;
		end else begin
			if (wr && hit(paddr, `DTC_ADDR_IRQ_STAT)) begin
				stat_q <= ev | (stat_q & ~pwdata[3:0]);
			end else begin
				stat_q <= ev | stat_q;
			end
			if (wr && hit(paddr, `DTC_ADDR_IRQ_MASK)) begin
				mask_q <= pwdata[3:0];
			end
		end
	end

	// ***************
	// outputs and apb read
	// ***************
	logic [31:0] rd;
	logic known;
	always_comb begin
		rd = 32'h0000_0000;
		known = 1'b1;
		if (hit(paddr, `DTC_ADDR_CTRL)) begin
			rd = {24'h0, ctrl_q};
		end else if (hit(paddr, `DTC_ADDR_MODE)) begin
			rd = {24'h0, mode_q};
		end else if (hit(paddr, `DTC_ADDR_TL0)) begin
			rd = {24'h0, tl0_q};
		end else if (hit(paddr, `DTC_ADDR_TL1)) begin
			rd = {24'h0, tl1_q};
		end else if (hit(paddr, `DTC_ADDR_TH0)) begin
			rd = {24'h0, th0_q};
		end else if (hit(paddr, `DTC_ADDR_TH1)) begin
			rd = {24'h0, th1_q};
		end else if (hit(paddr, `DTC_ADDR_IRQ_STAT)) begin
			rd = {28'h0, stat_q};
		end else if (hit(paddr, `DTC_ADDR_IRQ_MASK)) begin
			rd = {28'h0, mask_q};
		end else begin
			known = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known;
			prdata <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_one_overflow_flag <= 1'b0;
			timer_zero_overflow_flag <= 1'b0;
			ext_int_one_request <= 1'b0;
			ext_int_zero_request <= 1'b0;
			irq <= 1'b0;
		end else begin
			timer_one_overflow_flag <= ctrl_q[`DTC_BIT_TF1];
			timer_zero_overflow_flag <= ctrl_q[`DTC_BIT_TF0];
			ext_int_one_request <= ctrl_q[`DTC_BIT_IT1] ? ctrl_q[`DTC_BIT_IE1]
				: !sync2_q.int_one;
			ext_int_zero_request <= ctrl_q[`DTC_BIT_IT0] ? ctrl_q[`DTC_BIT_IE0]
				: !sync2_q.int_zero;
			irq <= |(stat_q & mask_q);
		end
	end

	// ***************
	// checks
	// ***************
	property p_run1;
		@(posedge clk) disable iff (!reset_n)
		!ctrl_q[`DTC_BIT_TR1] && !wr |=> $stable(th1_q) && $stable(tl1_q);
	endproperty
	a_run1: assert property (p_run1) else $error("timer one moved while halted");
	property p_run0;
		@(posedge clk) disable iff (!reset_n)
		!ctrl_q[`DTC_BIT_TR0] && !wr && m0 != DTC_MODE_SPLIT |=> $stable(tl0_q) && $stable(th0_q);
	endproperty
	a_run0: assert property (p_run0) else $error("timer zero moved while halted");
	property p_tf1;
		@(posedge clk) disable iff (!reset_n)
		ovf1 |=> ctrl_q[`DTC_BIT_TF1];
	endproperty
	a_tf1: assert property (p_tf1) else $error("timer one flag not set");
	property p_tf0;
		@(posedge clk) disable iff (!reset_n)
		ovf0 |=> ctrl_q[`DTC_BIT_TF0];
	endproperty
	a_tf0: assert property (p_tf0) else $error("timer zero flag not set");
	property p_ie1;
		@(posedge clk) disable iff (!reset_n)
		ctrl_q[`DTC_BIT_IT1] && prev_q.int_one && !sync2_q.int_one |=> ctrl_q[`DTC_BIT_IE1];
	endproperty
	a_ie1: assert property (p_ie1) else $error("int one edge missed");
	property p_ie0;
		@(posedge clk) disable iff (!reset_n)
		ctrl_q[`DTC_BIT_IT0] && prev_q.int_zero && !sync2_q.int_zero |=> ctrl_q[`DTC_BIT_IE0];
	endproperty
	a_ie0: assert property (p_ie0) else $error("int zero edge missed");
	property p_lvl0;
		@(posedge clk) disable iff (!reset_n)
		!ctrl_q[`DTC_BIT_IT0] |=> ext_int_zero_request == !$past(sync2_q.int_zero);
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("int zero level wrong");
	property p_timer_one_pin_gating;
		@(posedge clk) disable iff (!reset_n)
		mode_q[`DTC_BIT_TIMER_ONE_PIN_GATING] && !sync2_q.int_one && !wr |=> $stable(tl1_q) && $stable(th1_q);
	endproperty
	a_timer_one_pin_gating: assert property (p_timer_one_pin_gating) else $error("gated timer one counted");
	property p_stop1;
		@(posedge clk) disable iff (!reset_n)
		m1 == DTC_MODE_SPLIT && !wr |=> $stable(tl1_q) && $stable(th1_q);
	endproperty
	a_stop1: assert property (p_stop1) else $error("timer one ran in mode three");
endmodule

// ===== sim/dtc_cpu_pins_model.sv
// cpu vectoring and external pin model for the dual timer/counter
`timescale 1ns/1ps
module dtc_cpu_pins_model import dtc_pkg::*; (
	input wire logic clk,
	output dtc_pins_s pins,
	output dtc_ack_s vector_ack
);
	// ************************************
	// pins idle high, ack idle low
	// ************************************
	initial begin
		pins = '1;
		vector_ack = '0;
	end
	// n low pulses on masked pins, 4 cycles low then 4 high
	task automatic fall(input logic [3:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			pins <= dtc_pins_s'(pins & ~m);
			repeat (4) @(posedge clk);
			pins <= dtc_pins_s'(pins | m);
			repeat (4) @(posedge clk);
		end
	endtask
	// hold masked pins at a level
	task automatic hold(input logic [3:0] m, input logic lvl);
		@(posedge clk);
		pins <= lvl ? dtc_pins_s'(pins | m) : dtc_pins_s'(pins & ~m);
	endtask
	// one-cycle vectoring pulse
	task automatic ack(input logic [3:0] m);
		@(posedge clk);
		vector_ack <= dtc_ack_s'(m);
		@(posedge clk);
		vector_ack <= '0;
	endtask
endmodule

// ===== sim/dual_timer_counter_ext_int_tb_top.sv
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`include "dtc_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module dual_timer_counter_ext_int_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rdat, v;
	logic pready, pslverr, perr, tf1_o, tf0_o, ei1, ei0, irq;
	dtc_pkg::dtc_pins_s pins;
	dtc_pkg::dtc_ack_s vack;
	int error_cnt = 0;
	int comparisons = 0;
	localparam logic [11:0] a_ctl = `DTC_ADDR_CTRL, a_mod = `DTC_ADDR_MODE;
	localparam logic [11:0] a_lo0 = `DTC_ADDR_TL0, a_lo1 = `DTC_ADDR_TL1;
	localparam logic [11:0] a_hi0 = `DTC_ADDR_TH0, a_hi1 = `DTC_ADDR_TH1;
	localparam logic [11:0] a_st = `DTC_ADDR_IRQ_STAT, a_mk = `DTC_ADDR_IRQ_MASK;
	always #5 clk = ~clk;
	dtc_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .vector_ack(vack),
		.timer_one_overflow_flag(tf1_o), .timer_zero_overflow_flag(tf0_o),
		.ext_int_one_request(ei1), .ext_int_zero_request(ei0), .irq(irq));
	dtc_cpu_pins_model cpu (.clk(clk), .pins(pins), .vector_ack(vack));
	// ************************************
	// apb tasks
	// ************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic poll(input int b);
		for (int i = 0; i < 40; i++) begin
			rd(a_ctl);
			if (rdat[b] === 1'b1) break;
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ************************************
	// tests
	// ************************************
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rd(a_ctl); `CHK(rdat, 32'h0)
		rd(a_mod); `CHK(rdat, 32'h0)
		rd(12'h090); `CHK(perr, 1'b1)
		wr(a_mod, 8'h01); wr(a_lo0, 8'hFE); wr(a_hi0, 8'hFF); wr(a_ctl, 8'h10); poll(5);
		`CHK(rdat[5], 1'b1)
		repeat (2) @(posedge clk);
		`CHK(tf0_o, 1'b1)
		wr(a_ctl, 8'h20); rd(a_hi0); `CHK(rdat, 32'h0)
		rd(a_lo0); v = rdat; repeat (10) @(posedge clk);
		rd(a_lo0); `CHK(rdat, v)
		wr(a_mk, 8'h04); repeat (2) @(posedge clk); `CHK(irq, 1'b1)
		wr(a_st, 8'h04); repeat (2) @(posedge clk); `CHK(irq, 1'b0)
		cpu.ack(4'b0100); rd(a_ctl); `CHK(rdat[5], 1'b0)
		wr(a_mod, 8'h02); wr(a_hi0, 8'h80); wr(a_lo0, 8'hFE); wr(a_ctl, 8'h10); poll(5);
		wr(a_ctl, 8'h00); rd(a_hi0); `CHK(rdat, 32'h80)
		rd(a_lo0); `CHK(rdat[7], 1'b1)
		wr(a_mod, 8'h00); wr(a_lo0, 8'h1F); wr(a_hi0, 8'hFF); wr(a_ctl, 8'h10); poll(5);
		`CHK(rdat[5], 1'b1)
		wr(a_ctl, 8'h00); wr(a_mod, 8'h03); wr(a_hi0, 8'hFF); wr(a_ctl, 8'h40); poll(7);
		`CHK(rdat[7], 1'b1)
		wr(a_ctl, 8'h00); wr(a_mod, 8'h10); wr(a_lo1, 8'hFE); wr(a_hi1, 8'hFF);
		wr(a_ctl, 8'h40); poll(7); `CHK(rdat[7], 1'b1)
		repeat (2) @(posedge clk); `CHK(tf1_o, 1'b1)
		cpu.ack(4'b1000); rd(a_ctl); `CHK(rdat[7], 1'b0)
		wr(a_ctl, 8'h00); wr(a_mod, 8'h30); wr(a_lo1, 8'h05); wr(a_ctl, 8'h40);
		repeat (20) @(posedge clk); rd(a_lo1); `CHK(rdat, 32'h05)
		wr(a_ctl, 8'h00); wr(a_mod, 8'h55); wr(a_lo0, 8'h00); wr(a_lo1, 8'h00);
		wr(a_ctl, 8'h50); cpu.fall(4'b0011, 3); repeat (6) @(posedge clk);
		rd(a_lo1); `CHK(rdat, 32'h03)
		rd(a_lo0); `CHK(rdat, 32'h03)
		wr(a_ctl, 8'h00); wr(a_mod, 8'h99); wr(a_lo0, 8'h00); wr(a_lo1, 8'h00);
		cpu.hold(4'b1100, 1'b0);
		wr(a_ctl, 8'h50); repeat (20) @(posedge clk);
		rd(a_lo0); `CHK(rdat, 32'h0)
		rd(a_lo1); `CHK(rdat, 32'h0)
		`CHK(ei0, 1'b1)
		`CHK(ei1, 1'b1)
		cpu.hold(4'b1100, 1'b1); repeat (20) @(posedge clk);
		rd(a_lo0); `CHK(rdat[7:0] != 8'h00, 1'b1)
		rd(a_lo1); `CHK(rdat[7:0] != 8'h00, 1'b1)
		`CHK(ei0, 1'b0)
		`CHK(ei1, 1'b0)
		wr(a_ctl, 8'h04); cpu.fall(4'b0100, 1); rd(a_ctl);
		`CHK(rdat[3], 1'b1)
		`CHK(ei1, 1'b1)
		cpu.ack(4'b0010); rd(a_ctl); `CHK(rdat[3], 1'b0)
		wr(a_ctl, 8'h01); cpu.fall(4'b1000, 1); rd(a_ctl);
		`CHK(rdat[1], 1'b1)
		end_of_test();
	end
endmodule
